// ===== src/pub_pkg.sv
// constants, field layouts and bus codes for the presettable up/down counter
// assumes a 32-bit AHB-Lite bus with word-aligned single transfers
package pub_pkg;

	localparam int CNT_W = 4;

	// count limits for the two modes
	localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
	localparam logic [CNT_W-1:0] BIN_MAX  = 4'hf;
	localparam logic [CNT_W-1:0] DEC_MAX  = 4'h9;
	localparam logic [CNT_W-1:0] CNT_ONE  = 4'h1;
	localparam logic [CNT_W-1:0] CNT_RST  = 4'h0;

	// register byte offsets
	localparam int ADDR_W = 32;
	localparam int OFS_W  = 8;
	localparam logic [OFS_W-1:0] OFS_CTRL = 8'h00;
	localparam logic [OFS_W-1:0] OFS_STEP = 8'h04;
	localparam logic [OFS_W-1:0] OFS_STAT = 8'h08;
	localparam logic [ADDR_W-OFS_W-1:0] ADDR_HI_ZERO = 24'h00_0000;

	localparam int STEP_BIT = 0;
	localparam int CTRL_W   = 8;
	localparam int STAT_W   = 5;
	localparam int DATA_W   = 32;

	// ahb-lite codes
	localparam logic [1:0]        HTRANS_IDLE  = 2'h0;
	localparam logic [1:0]        HTRANS_NSEQ  = 2'h2;
	localparam logic              HRESP_OKAY   = 1'h0;
	localparam logic [DATA_W-1:0] RDATA_ZERO   = 32'h0000_0000;

	// control register, bit 0 is load
	typedef struct packed {
		logic [CNT_W-1:0] data;
		logic             up;
		logic             binary;
		logic             inhibit;
		logic             load;
	} pub_ctrl_t;

	localparam pub_ctrl_t CTRL_RST = 8'h00;

	// status register, bit 4 is the active-low terminal count
	typedef struct packed {
		logic             tc_n;
		logic [CNT_W-1:0] count;
	} pub_stat_t;

endpackage

// ===== src/pub_step.sv
// next-count and end-of-range logic for one step of the counter
// assumes a four-bit count; purely combinational
`timescale 1ns/1ps
`default_nettype none

module pub_step
	import pub_pkg::*;
(
	input  wire logic [CNT_W-1:0] count_in,
	input  wire logic             binary_in,
	input  wire logic             up_in,
	output logic      [CNT_W-1:0] next_out,
	output logic                  at_end_out
);

	wire logic [CNT_W-1:0] top_val;
	wire logic             at_top;
	wire logic             at_zero;

	assign top_val = binary_in ? BIN_MAX : DEC_MAX;
	assign at_top  = (count_in == top_val);
	assign at_zero = (count_in == CNT_ZERO);

	// out-of-range decade values simply step through: counting up they wrap at fifteen, counting down they fall back to nine
	assign next_out = up_in ? (at_top ? CNT_ZERO : count_in + CNT_ONE)
	                        : (at_zero ? top_val : count_in - CNT_ONE);
	assign at_end_out = up_in ? at_top : at_zero;

endmodule

`default_nettype wire

// ===== src/pub_counter.sv
// presettable four-bit up/down binary/decade counter with ahb-lite register access
// assumes a single ahb-lite master, zero-wait-state slave, synchronous inputs on clk_in
//
// Contract
// - keep a four-stage count that counts binary or decade, up or down, with a terminal-count carry in both modes.
// - offer four count outputs, one carry output, and inputs for clock, carry-in, mode, direction, load and data.
// - while load is enabled the count takes the parallel data at once, without a count step.
// - load with all data bits low forces the count to zero, which is the only clear; the code also clears the count to zero on rst_in.
// - a count step changes the count by exactly one, only with carry-in and load both low.
// - with carry-in or load high the count holds across count steps.
// - the carry output is high except while carry-in is low and the count sits at its end of range.
// - mode high counts pure binary, mode low counts decade in bcd.
// - direction high counts up, direction low counts down.
//
// Register access over AHB-Lite and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module pub_counter
	import pub_pkg::*;
(
	input  wire logic              clk_in,
	input  wire logic              rst_in,
	input  wire logic              hsel_in,
	input  wire logic [ADDR_W-1:0] haddr_in,
	input  wire logic [1:0]        htrans_in,
	input  wire logic              hwrite_in,
	input  wire logic [2:0]        hsize_in,
	input  wire logic [DATA_W-1:0] hwdata_in,
	input  wire logic              hready_in,
	output logic                   hreadyout_out,
	output logic                   hresp_out,
	output logic      [DATA_W-1:0] hrdata_out,
	output logic      [CNT_W-1:0]  count_out,
	output logic                   terminal_count_out
);

	pub_ctrl_t         ctrl_ff;
	logic [CNT_W-1:0]  count_ff;
	logic              tc_n_ff;
	logic              wr_pend_ff;
	logic [OFS_W-1:0]  wr_ofs_ff;
	logic [DATA_W-1:0] rdata_ff;
	logic              ready_ff;

	// address phase decode
	wire logic             addr_take;
	wire logic             addr_hi_ok;
	wire logic [OFS_W-1:0] addr_ofs;

	assign addr_take  = hsel_in & hready_in & htrans_in[1];
	assign addr_hi_ok = (haddr_in[ADDR_W-1:OFS_W] == ADDR_HI_ZERO);
	assign addr_ofs   = haddr_in[OFS_W-1:0];

	// data phase writes
	wire logic      wr_ctrl;
	wire logic      wr_step;
	wire logic      step_req;
	wire pub_ctrl_t nxt_ctrl;

	assign wr_ctrl  = wr_pend_ff & (wr_ofs_ff == OFS_CTRL);
	assign wr_step  = wr_pend_ff & (wr_ofs_ff == OFS_STEP);
	assign step_req = wr_step & hwdata_in[STEP_BIT];
	assign nxt_ctrl = wr_ctrl ? pub_ctrl_t'(hwdata_in[CTRL_W-1:0]) : ctrl_ff;

	// step value for the settings standing before the step
	wire logic [CNT_W-1:0] step_val;

	pub_step u_step_now (
		.count_in   (count_ff),
		.binary_in  (ctrl_ff.binary),
		.up_in      (ctrl_ff.up),
		.next_out   (step_val),
		.at_end_out ()
	);

	// a step only counts with carry-in and load low, and a new load wins
	wire logic             step_go;
	wire logic [CNT_W-1:0] nxt_count;

	assign step_go   = step_req & ~ctrl_ff.inhibit & ~ctrl_ff.load & ~nxt_ctrl.load;
	assign nxt_count = nxt_ctrl.load ? nxt_ctrl.data
	                 : (step_go ? step_val : count_ff);

	// the carry is judged on next-state values so the registered output shows no lag
	wire logic             nxt_end;
	wire logic             nxt_tc_n;

	pub_step u_step_next (
		.count_in   (nxt_count),
		.binary_in  (nxt_ctrl.binary),
		.up_in      (nxt_ctrl.up),
		.next_out   (),
		.at_end_out (nxt_end)
	);

	assign nxt_tc_n = ~(~nxt_ctrl.inhibit & nxt_end);

	// read mux also uses next-state values, so a read right after a write sees it
	wire pub_stat_t        nxt_stat;
	wire logic [DATA_W-1:0] rd_mux;
	wire logic [DATA_W-1:0] nxt_rdata;

	assign nxt_stat  = '{tc_n: nxt_tc_n, count: nxt_count};
	assign rd_mux    = (addr_ofs == OFS_CTRL) ? {{(DATA_W-CTRL_W){1'b0}}, nxt_ctrl}
	                 : (addr_ofs == OFS_STAT) ? {{(DATA_W-STAT_W){1'b0}}, nxt_stat}
	                 : RDATA_ZERO;
	assign nxt_rdata = (addr_take & ~hwrite_in & addr_hi_ok) ? rd_mux : RDATA_ZERO;

	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			wr_pend_ff <= 1'b0;
			wr_ofs_ff  <= OFS_CTRL;
			rdata_ff   <= RDATA_ZERO;
			ready_ff   <= 1'b1;
		end
		else
		begin
			wr_pend_ff <= addr_take & hwrite_in & addr_hi_ok;
			wr_ofs_ff  <= addr_ofs;
			rdata_ff   <= nxt_rdata;
			ready_ff   <= 1'b1;
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			ctrl_ff  <= CTRL_RST;
			count_ff <= CNT_RST;
			// reset leaves zero, counting down, carry-in low: already the end of range
			tc_n_ff  <= 1'b0;
		end
		else
		begin
			ctrl_ff  <= nxt_ctrl;
			count_ff <= nxt_count;
			tc_n_ff  <= nxt_tc_n;
		end
	end

	assign hreadyout_out      = ready_ff;
	assign hresp_out          = HRESP_OKAY;
	assign hrdata_out         = rdata_ff;
	assign count_out          = count_ff;
	assign terminal_count_out = tc_n_ff;

	// checks

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);

	wire logic [CNT_W-1:0] chk_top;
	wire logic             chk_end;

	assign chk_top = ctrl_ff.binary ? BIN_MAX : DEC_MAX;
	assign chk_end = ctrl_ff.up ? (count_ff == chk_top) : (count_ff == CNT_ZERO);

	sequence s_step_up_mid;
		step_go ##0 ctrl_ff.up ##0 (count_ff != chk_top);
	endsequence

	sequence s_step_up_top;
		step_go ##0 ctrl_ff.up ##0 (count_ff == chk_top);
	endsequence

	sequence s_step_dn_zero;
		step_go ##0 !ctrl_ff.up ##0 (count_ff == CNT_ZERO);
	endsequence

	load_follow_a: assert property (ctrl_ff.load |-> count_ff == ctrl_ff.data)
		else $error("count does not follow parallel data under load");

	load_now_a: assert property (nxt_ctrl.load |=> count_ff == $past(nxt_ctrl.data))
		else $error("load did not take the parallel data at once");

	zero_load_a: assert property (ctrl_ff.load && ctrl_ff.data == CNT_ZERO |-> count_ff == CNT_ZERO)
		else $error("load of zero data did not clear the count");

	step_up_a: assert property (s_step_up_mid |=> count_ff == $past(count_ff) + CNT_ONE)
		else $error("up step did not add exactly one");

	step_down_a: assert property (step_go && !ctrl_ff.up && count_ff != CNT_ZERO
		|=> count_ff == $past(count_ff) - CNT_ONE)
		else $error("down step did not subtract exactly one");

	hold_count_a: assert property (!step_go && !nxt_ctrl.load |=> $stable(count_ff))
		else $error("count moved without a permitted step or load");

	inhibit_hold_a: assert property (step_req && ctrl_ff.inhibit && !nxt_ctrl.load
		|=> $stable(count_ff) ##1 1'b1)
		else $error("count stepped while carry-in was high");

	carry_value_a: assert property (terminal_count_out == !(!ctrl_ff.inhibit && chk_end))
		else $error("carry output disagrees with count and carry-in");

	carry_inhibit_a: assert property ($rose(ctrl_ff.inhibit) |-> terminal_count_out)
		else $error("carry output stayed low after carry-in rose");

	carry_release_a: assert property ($fell(ctrl_ff.inhibit) && chk_end |-> !terminal_count_out)
		else $error("carry output stayed high after carry-in fell at end of range");

	wrap_up_a: assert property (s_step_up_top |=> count_ff == CNT_ZERO)
		else $error("up count did not wrap to zero");

	wrap_down_a: assert property (s_step_dn_zero |=> count_ff == $past(chk_top))
		else $error("down count did not wrap to the mode maximum");

	decade_range_a: assert property (step_go && !ctrl_ff.binary && count_ff <= DEC_MAX
		|=> count_ff <= DEC_MAX)
		else $error("decade step left the bcd range");

	bus_okay_a: assert property (hreadyout_out && hresp_out == HRESP_OKAY)
		else $error("slave did not answer ready and okay");

	// read data stands only in the data phase of a taken read
	rdata_idle_a: assert property (!(addr_take && !hwrite_in && addr_hi_ok) |=> hrdata_out == RDATA_ZERO)
		else $error("read data showed outside a read data phase");

endmodule

`default_nettype wire

// ===== sim/pub_ahb_ctl.sv
// ahb-lite master standing in for the controlling logic of the counter
// assumes the one slave's hreadyout is the bus hready and shares clk_in
`timescale 1ns/1ps
`default_nettype none

module pub_ahb_ctl
	import pub_pkg::*;
(
	input  wire logic              clk_in,
	input  wire logic              hready_in,
	input  wire logic [DATA_W-1:0] hrdata_in,
	output logic      [ADDR_W-1:0] haddr_out,
	output logic      [1:0]        htrans_out,
	output logic                   hwrite_out,
	output logic      [2:0]        hsize_out,
	output logic      [DATA_W-1:0] hwdata_out
);
	initial
	begin
		haddr_out  = '0;
		htrans_out = HTRANS_IDLE;
		hwrite_out = 1'b0;
		hsize_out  = 3'h2;
		hwdata_out = '0;
	end

	// single word transfer on the common clock; only the bench watchdog ends a wait
	task automatic xfer(input logic [ADDR_W-1:0] a, input logic w, input logic [DATA_W-1:0] d,
		output logic [DATA_W-1:0] r);
		@(posedge clk_in);
		haddr_out  <= a;
		htrans_out <= HTRANS_NSEQ;
		hwrite_out <= w;
		@(posedge clk_in);
		while (hready_in !== 1'b1)
			@(posedge clk_in);
		htrans_out <= HTRANS_IDLE;
		hwdata_out <= d;
		@(posedge clk_in);
		while (hready_in !== 1'b1)
			@(posedge clk_in);
		r = hrdata_in;
		// released data lines must not keep showing the old word
		hwdata_out <= ~d;
	endtask
endmodule

`default_nettype wire

// ===== sim/testbench.sv
// self-checking bench for the up/down counter, driven over ahb-lite
// assumes pub_counter as the slave and pub_ahb_ctl as the master
`timescale 1ns/1ps
`default_nettype none

module testbench
	import pub_pkg::*;
;
	localparam logic [ADDR_W-1:0] A_CTRL = {ADDR_HI_ZERO, OFS_CTRL};
	localparam logic [ADDR_W-1:0] A_STEP = {ADDR_HI_ZERO, OFS_STEP};
	localparam logic [ADDR_W-1:0] A_STAT = {ADDR_HI_ZERO, OFS_STAT};
	logic              clk_in;
	logic              rst_in;
	logic [ADDR_W-1:0] haddr;
	logic [1:0]        htrans;
	logic              hwrite;
	logic [2:0]        hsize;
	logic [DATA_W-1:0] hwdata;
	logic              hready;
	logic              hresp;
	logic [DATA_W-1:0] hrdata;
	logic [CNT_W-1:0]  count;
	logic              tc_n;
	logic [DATA_W-1:0] rd;
	int                errors;
	int                n_checks;
	// control bytes {data, up, binary, inhibit, load} and the count after one step
	logic [7:0]        tbl [7]  = '{8'hec, 8'hfc, 8'h88, 8'h98, 8'h00, 8'h10, 8'h04};
	logic [3:0]        nxt [7]  = '{4'hf, 4'h0, 4'h9, 4'h0, 4'h9, 4'h0, 4'hf};
	logic [31:0]       zro [3]  = '{32'h4, 32'hc, 32'h100};

	pub_counter dut (.clk_in(clk_in), .rst_in(rst_in), .hsel_in(1'b1), .haddr_in(haddr),
		.htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata),
		.hready_in(hready), .hreadyout_out(hready), .hresp_out(hresp), .hrdata_out(hrdata),
		.count_out(count), .terminal_count_out(tc_n));
	pub_ahb_ctl mst (.clk_in(clk_in), .hready_in(hready), .hrdata_in(hrdata), .haddr_out(haddr),
		.htrans_out(htrans), .hwrite_out(hwrite), .hsize_out(hsize), .hwdata_out(hwdata));

	function automatic logic tc_exp(input logic [3:0] c, input logic [7:0] k);
		tc_exp = k[1] | (k[3] ? c != (k[2] ? BIN_MAX : DEC_MAX) : c != CNT_ZERO);
	endfunction

	task automatic check(input string nm, input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		mst.xfer(a, 1'b1, d, rd);
		#1;
	endtask

	task automatic stat(input logic [3:0] c, input logic t);
		mst.xfer(A_STAT, 1'b0, '0, rd);
		check("stat", rd, {27'h0, t, c});
		#1;
		check("count_out", {28'h0, count}, {28'h0, c});
		check("tc_out", {31'h0, tc_n}, {31'h0, t});
	endtask

	task automatic complete_run();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	initial
	begin
		clk_in = 1'b0;
		forever #25 clk_in = ~clk_in;
	end

	initial
	begin
		#(2000 * 50);
		errors++;
		complete_run();
	end

	initial
	begin
		errors = 0;
		n_checks = 0;
		rst_in = 1'b1;
		repeat (3) @(posedge clk_in);
		rst_in <= 1'b0;
		stat(CNT_ZERO, 1'b0);
		for (int i = 0; i < 7; i++)
		begin
			wr(A_CTRL, {24'h0, tbl[i] | 8'h01});
			stat(tbl[i][7:4], tc_exp(tbl[i][7:4], tbl[i]));
			wr(A_CTRL, {24'h0, tbl[i]});
			wr(A_STEP, 32'h1);
			stat(nxt[i], tc_exp(nxt[i], tbl[i]));
		end
		wr(A_CTRL, 32'h0e);
		stat(BIN_MAX, 1'b1);
		wr(A_STEP, 32'h1);
		stat(BIN_MAX, 1'b1);
		wr(A_CTRL, 32'h0c);
		stat(BIN_MAX, 1'b0);
		wr(A_CTRL, 32'h01);
		stat(CNT_ZERO, 1'b0);
		wr(A_CTRL, 32'h55);
		wr(A_STEP, 32'h1);
		stat(4'h5, 1'b1);
		mst.xfer(A_CTRL, 1'b0, '0, rd);
		check("ctrl", rd, 32'h55);
		for (int i = 0; i < 3; i++)
		begin
			mst.xfer(zro[i], 1'b0, '0, rd);
			check("unmapped", rd, RDATA_ZERO);
		end
		check("hresp", {31'h0, hresp}, {31'h0, HRESP_OKAY});
		complete_run();
	end
endmodule

`default_nettype wire
